/* File: core/sram_port_pkg.sv */
// sram_port_pkg: widths, reset values, modes and carriers shared by the pipelined burst sram port.
// assumes every user sits in the single clk domain of the port.
package sram_port_pkg;

    // geometry of one stored word
    localparam int ADDR_W = 20;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = BYTE_W + 1;
    localparam int DATA_W = LANES * BYTE_W;
    localparam int WORD_W = LANES * LANE_W;
    localparam int CHECK_W = 6;

    // burst counter
    localparam int BEAT_W = 2;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;

    // reset values
    localparam logic SLEEP_RESET = 1'b0;
    localparam logic DRIVE_RESET = 1'b0;

    typedef enum logic {
        ORDER_LINEAR = 1'b0,
        ORDER_INTERLEAVED = 1'b1
    } order_e;

    typedef enum logic {
        POWER_AWAKE = 1'b0,
        POWER_ASLEEP = 1'b1
    } power_e;

    // one access travelling down the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] mask;
    } access_s;

    localparam access_s ACCESS_IDLE = '0;

    // lane k of a stored word is {parity k, byte k}
    function automatic logic [WORD_W-1:0] join_lanes(input logic [DATA_W-1:0] d, input logic [LANES-1:0] p);
        logic [WORD_W-1:0] w;
        w = '0;
        for (int k = 0; k < LANES; k++) begin
            w[k*LANE_W +: LANE_W] = {p[k], d[k*BYTE_W +: BYTE_W]};
        end
        return w;
    endfunction : join_lanes

endpackage : sram_port_pkg

/* File: core/burst_sequencer.sv */
// burst_sequencer: two-bit burst address generator, linear or interleaved.
// assumes load and advance are already qualified by the caller and never high together.
`timescale 1ns/100ps
module burst_sequencer import sram_port_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic load,
    input wire logic advance,
    input wire logic [BEAT_W-1:0] start_low,
    input wire order_e order,
    // result for the access taken at this edge
    output logic [BEAT_W-1:0] addr_low
);

    logic [BEAT_W-1:0] start;
    logic [BEAT_W-1:0] beat;
    logic [BEAT_W-1:0] next_beat;

    // two-bit arithmetic wraps inside the four-word group
    assign next_beat = beat + BEAT_STEP;

    always_comb begin
        if (load) begin
            addr_low = start_low;
        end else if (order == ORDER_INTERLEAVED) begin
            addr_low = start ^ next_beat;
        end else begin
            addr_low = start + next_beat;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start <= BEAT_FIRST;
            beat <= BEAT_FIRST;
        end else if (load) begin
            start <= start_low;
            beat <= BEAT_FIRST;
        end else if (advance) begin
            beat <= next_beat;
        end
    end

endmodule : burst_sequencer

/* File: core/ecc_hamming.sv */
// ecc_hamming: single-error-correcting hamming code over one stored word.
// assumes at most one flipped bit per word; a double error is miscorrected, not flagged.
`timescale 1ns/100ps
module ecc_hamming import sram_port_pkg::*; (
    // encoder
    input wire logic [WORD_W-1:0] enc_word,
    output logic [CHECK_W-1:0] enc_check,
    // decoder
    input wire logic [WORD_W-1:0] dec_word,
    input wire logic [CHECK_W-1:0] dec_check,
    output logic [WORD_W-1:0] dec_fixed,
    output logic dec_corrected
);

    // codeword position of data bit idx: positions that are not powers of two
    function automatic logic [CHECK_W-1:0] bit_position(input int idx);
        int n;
        logic [CHECK_W-1:0] pos;
        n = 0;
        pos = '0;
        for (int q = 3; q < 2**CHECK_W; q++) begin
            if ((q & (q - 1)) != 0) begin
                if (n == idx) begin
                    pos = CHECK_W'(q);
                end
                n++;
            end
        end
        return pos;
    endfunction : bit_position

    function automatic logic [CHECK_W-1:0] check_of(input logic [WORD_W-1:0] w);
        logic [CHECK_W-1:0] c;
        c = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (w[i]) begin
                c = c ^ bit_position(i);
            end
        end
        return c;
    endfunction : check_of

    logic [CHECK_W-1:0] syndrome;

    assign enc_check = check_of(enc_word);
    assign syndrome = dec_check ^ check_of(dec_word);
    // a syndrome that is a power of two hits a check bit only; data stays as read
    assign dec_corrected = (syndrome != '0);

    generate
        for (genvar i = 0; i < WORD_W; i++) begin : g_fix
            assign dec_fixed[i] = dec_word[i] ^ (syndrome == bit_position(i));
        end
    endgenerate

endmodule : ecc_hamming

/* File: core/pipelined_burst_sram_port.sv */
// pipelined_burst_sram_port: synchronous pipelined burst sram with byte writes, sleep and ecc.
// assumes the controller runs on clk; only sleep_request is asynchronous to it.
`timescale 1ns/100ps
module pipelined_burst_sram_port import sram_port_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command inputs
    input wire logic clock_qualify_n,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [LANES-1:0] byte_lane_mask_n,
    input wire order_e burst_order_select,
    input wire logic output_drive_n,
    input wire logic sleep_request,
    // shared data lines
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [LANES-1:0] parity_lines_in,
    output logic [LANES-1:0] parity_lines_out,
    output logic parity_lines_oe,
    // status
    output power_e power_state,
    output logic ecc_corrected
);

    // storage: data lanes plus hidden check bits
    logic [CHECK_W+WORD_W-1:0] mem [0:2**ADDR_W-1];

    // sleep synchroniser
    logic sleep_meta;
    logic sleep_sync;
    logic sleeping;

    // command decode
    logic run;
    logic selected;
    logic load;
    logic advance;

    // burst state
    logic burst_valid;
    logic burst_write;
    logic [ADDR_W-BEAT_W-1:0] burst_base;
    logic [BEAT_W-1:0] addr_low;

    // pipeline
    access_s next_s1;
    access_s s1;
    access_s s2;

    // read and write paths
    logic [CHECK_W+WORD_W-1:0] rd_raw;
    logic [CHECK_W+WORD_W-1:0] old_raw;
    logic [WORD_W-1:0] rd_fixed;
    logic rd_corrected;
    logic [WORD_W-1:0] old_fixed;
    logic [WORD_W-1:0] in_word;
    logic [WORD_W-1:0] merged;
    logic [CHECK_W-1:0] merged_check;
    logic commit;
    logic forward;

    // output register
    logic out_valid;
    logic [WORD_W-1:0] out_word;

    // sleep_request is asynchronous; the two flops are also the two-cycle entry and exit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_meta <= SLEEP_RESET;
            sleep_sync <= SLEEP_RESET;
        end else begin
            sleep_meta <= sleep_request;
            sleep_sync <= sleep_meta;
        end
    end

    assign sleeping = sleep_sync;
    assign power_state = sleeping ? POWER_ASLEEP : POWER_AWAKE;

    // a high qualifier or sleep freezes the edge
    assign run = !clock_qualify_n && !sleeping;
    assign selected = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    assign load = run && !advance_or_load;
    assign advance = run && advance_or_load;

    burst_sequencer u_burst (
        .clk(clk),
        .rstn(rstn),
        .load(load),
        .advance(advance),
        .start_low(address[BEAT_W-1:0]),
        .order(burst_order_select),
        .addr_low(addr_low)
    );

    // burst type and base are latched only at a load edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burst_valid <= 1'b0;
            burst_write <= 1'b0;
            burst_base <= '0;
        end else if (sleeping) begin
            burst_valid <= 1'b0;
        end else if (load) begin
            burst_valid <= selected;
            burst_write <= !write_n;
            burst_base <= address[ADDR_W-1:BEAT_W];
        end
    end

    always_comb begin
        next_s1 = ACCESS_IDLE;
        // masks are sampled per beat, so the controller must repeat them
        next_s1.mask = ~byte_lane_mask_n;
        if (advance_or_load) begin
            next_s1.valid = burst_valid;
            next_s1.write = burst_write;
            next_s1.addr = {burst_base, addr_low};
        end else begin
            next_s1.valid = selected;
            next_s1.write = !write_n;
            next_s1.addr = {address[ADDR_W-1:BEAT_W], addr_low};
        end
    end

    // first stage: the command edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= ACCESS_IDLE;
        end else if (sleeping) begin
            // the controller has deselected before sleep, so nothing valid is lost here
            s1 <= ACCESS_IDLE;
        end else if (run) begin
            s1 <= next_s1;
        end
    end

    // second stage: the edge after the command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s2 <= ACCESS_IDLE;
        end else if (sleeping) begin
            s2 <= ACCESS_IDLE;
        end else if (run) begin
            s2 <= s1;
        end
    end

    assign rd_raw = mem[s1.addr];
    assign old_raw = mem[s2.addr];

    // read path corrects the word bound for the output register
    ecc_hamming u_ecc_read (
        .enc_word('0),
        .enc_check(),
        .dec_word(rd_raw[WORD_W-1:0]),
        .dec_check(rd_raw[CHECK_W+WORD_W-1:WORD_W]),
        .dec_fixed(rd_fixed),
        .dec_corrected(rd_corrected)
    );

    // write path corrects the old word, merges new lanes and encodes afresh
    ecc_hamming u_ecc_write (
        .enc_word(merged),
        .enc_check(merged_check),
        .dec_word(old_raw[WORD_W-1:0]),
        .dec_check(old_raw[CHECK_W+WORD_W-1:WORD_W]),
        .dec_fixed(old_fixed),
        .dec_corrected()
    );

    assign in_word = join_lanes(data_lines_in, parity_lines_in);

    // byte lane and its parity bit move together
    always_comb begin
        merged = old_fixed;
        for (int k = 0; k < LANES; k++) begin
            if (s2.mask[k]) begin
                merged[k*LANE_W +: LANE_W] = in_word[k*LANE_W +: LANE_W];
            end
        end
    end

    // write data is taken at the second edge after the command
    assign commit = run && s2.valid && s2.write;

    always_ff @(posedge clk) begin
        if (commit) begin
            mem[s2.addr] <= {merged_check, merged};
        end
    end

    // a read right behind a write to the same word must see the merged data
    assign forward = commit && (s1.addr == s2.addr);

    // output register, loaded at the edge after the read command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid <= DRIVE_RESET;
        end else if (sleeping) begin
            out_valid <= DRIVE_RESET;
        end else if (run) begin
            // writes and deselects clear it, so the lines float one edge later
            out_valid <= s1.valid && !s1.write;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_word <= '0;
            ecc_corrected <= 1'b0;
        end else if (run && s1.valid && !s1.write) begin
            out_word <= forward ? merged : rd_fixed;
            ecc_corrected <= !forward && rd_corrected;
        end
    end

    always_comb begin
        for (int k = 0; k < LANES; k++) begin
            data_lines_out[k*BYTE_W +: BYTE_W] = out_word[k*LANE_W +: BYTE_W];
            parity_lines_out[k] = out_word[k*LANE_W + BYTE_W];
        end
    end

    // output_drive_n gates the drivers directly; the controller turns it high before driving
    assign data_lines_oe = out_valid && !output_drive_n && !sleeping;
    assign parity_lines_oe = data_lines_oe;

endmodule : pipelined_burst_sram_port

/* File: dv/sram_port_asserts.sv */
// checker: output timing of the sram port against its command inputs.
// assumes one clk domain; sleep_request is watched raw.
`timescale 1ns/100ps
module sram_port_asserts import sram_port_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // commands
    input wire logic clock_qualify_n,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic output_drive_n,
    input wire logic sleep_request,
    // outputs
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe,
    input wire logic parity_lines_oe,
    input wire power_e power_state,
    input wire logic ecc_corrected
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic go;
    logic sel;
    assign go = !clock_qualify_n && power_state == POWER_AWAKE && !sleep_request;
    assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    read_drive_a: assert property (go && sel && !advance_or_load && write_n ##1 go ##1 !output_drive_n
        |-> data_lines_oe) else $error("read data not driven");
    write_float_a: assert property (go && sel && !advance_or_load && !write_n ##1 go
        |=> !data_lines_oe) else $error("data lines driven in write data cycle");
    deselect_float_a: assert property (go && !sel && !advance_or_load ##1 go
        |=> !data_lines_oe) else $error("data lines driven after deselect");
    lanes_paired_a: assert property (data_lines_oe == parity_lines_oe)
        else $error("parity enable differs from data enable");
    stall_hold_a: assert property (clock_qualify_n && power_state == POWER_AWAKE
        |=> $stable(data_lines_out) && $stable(ecc_corrected)) else $error("output moved on ignored edge");
    sleep_enter_a: assert property ($rose(sleep_request) |-> ##1 power_state == POWER_AWAKE
        ##1 power_state == POWER_ASLEEP) else $error("sleep entry not two cycles");
    sleep_exit_a: assert property ($fell(sleep_request) |-> ##1 power_state == POWER_ASLEEP
        ##1 power_state == POWER_AWAKE) else $error("sleep exit not two cycles");
    asleep_float_a: assert property (power_state == POWER_ASLEEP |-> !data_lines_oe)
        else $error("data lines driven while asleep");
    cover property (go && sel && !advance_or_load && write_n ##1 go ##1 data_lines_oe);
    cover property (go && sel && !advance_or_load && !write_n ##1 go ##1 advance_or_load);
    cover property (power_state == POWER_ASLEEP);
endmodule : sram_port_asserts

bind pipelined_burst_sram_port sram_port_asserts asserts_u (.clk(clk), .rstn(rstn),
    .clock_qualify_n(clock_qualify_n), .chip_select_one_n(chip_select_one_n),
    .chip_select_two(chip_select_two), .chip_select_three_n(chip_select_three_n),
    .advance_or_load(advance_or_load), .write_n(write_n), .output_drive_n(output_drive_n),
    .sleep_request(sleep_request), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .parity_lines_oe(parity_lines_oe), .power_state(power_state), .ecc_corrected(ecc_corrected));

/* File: dv/sram_master_model.sv */
// master model: drives write data two qualified edges after each write beat.
// assumes the bench queues one word per write beat, in issue order.
`timescale 1ns/100ps
module sram_master_model import sram_port_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command lines seen at the port
    input wire logic clock_qualify_n,
    input wire logic selected,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire power_e power_state,
    input wire logic data_lines_oe,
    // bus towards the device
    output logic [DATA_W-1:0] data_lines_in,
    output logic [LANES-1:0] parity_lines_in,
    output logic clash
);
    logic [LANES+DATA_W-1:0] q[$];
    logic [LANES+DATA_W-1:0] cur;
    logic in_write;
    logic pend;
    logic drv;
    task automatic load_word(input logic [LANES+DATA_W-1:0] w);
        q.push_back(w);
    endtask : load_word
    // a released bus shows the inverse, so stale data never passes for fresh
    assign {parity_lines_in, data_lines_in} = drv ? cur : ~cur;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {in_write, pend, drv, clash, cur} <= '0;
        end else begin
            if (drv && data_lines_oe) clash <= 1'b1;
            if (!clock_qualify_n && power_state == POWER_AWAKE) begin
                if (!advance_or_load) in_write <= selected && !write_n;
                pend <= advance_or_load ? in_write : selected && !write_n;
                drv <= pend;
                if (pend) cur <= q.pop_front();
            end
        end
    end
endmodule : sram_master_model

/* File: dv/test_pipelined_burst_sram_port.sv */
// bench: drives the port at the falling edge; the partner supplies write data.
// assumes reads only touch words already written.
`timescale 1ns/100ps
module test_pipelined_burst_sram_port import sram_port_pkg::*;;
    localparam int W = LANES + DATA_W;
    logic clk = 0, rstn = 0, qn = 0, cs1n = 1, cs2 = 0, cs3n = 1, adv = 0, wn = 1, odn = 0, slp = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [LANES-1:0] mask_n = '1, pli, plo;
    logic [DATA_W-1:0] dli, dlo;
    logic doe, poe, ecc, clash, want_v = 0;
    logic [W-1:0] want;
    logic [W-1:0] mem [logic [ADDR_W-1:0]];
    order_e order = ORDER_LINEAR;
    power_e pwr;
    int num_errors = 0, checked = 0;
    always #5 clk = ~clk;
    pipelined_burst_sram_port dut_u (.clk(clk), .rstn(rstn), .clock_qualify_n(qn), .chip_select_one_n(cs1n),
        .chip_select_two(cs2), .chip_select_three_n(cs3n), .advance_or_load(adv), .write_n(wn),
        .address(addr), .byte_lane_mask_n(mask_n), .burst_order_select(order), .output_drive_n(odn),
        .sleep_request(slp), .data_lines_in(dli), .data_lines_out(dlo), .data_lines_oe(doe),
        .parity_lines_in(pli), .parity_lines_out(plo), .parity_lines_oe(poe), .power_state(pwr),
        .ecc_corrected(ecc));
    sram_master_model master_u (.clk(clk), .rstn(rstn), .clock_qualify_n(qn), .selected(!cs1n && cs2 && !cs3n),
        .advance_or_load(adv), .write_n(wn), .power_state(pwr), .data_lines_oe(doe),
        .data_lines_in(dli), .parity_lines_in(pli), .clash(clash));
    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] nw, input logic [3:0] m);
        merge = old;
        for (int k = 0; k < LANES; k++) begin
            if (!m[k]) begin
                merge[DATA_W+k] = nw[DATA_W+k];
                merge[k*BYTE_W +: BYTE_W] = nw[k*BYTE_W +: BYTE_W];
            end
        end
    endfunction : merge
    // kind 0 deselect, 1 read, 2 write; a read is judged one edge after its own
    task automatic op(input int kind, input logic a, input logic [ADDR_W-1:0] ad, input logic [3:0] m,
            input logic [W-1:0] v);
        {adv, addr, mask_n} = {a, ad, m};
        {cs1n, cs2, cs3n} = (kind == 0 || a) ? 3'b101 : 3'b010;
        wn = (kind != 2) ^ a;
        if (kind == 2) begin
            master_u.load_word(v);
            mem[ad] = merge(mem.exists(ad) ? mem[ad] : v, v, m);
        end
        @(negedge clk);
        if (want_v) begin
            check({plo, dlo}, want);
            check(W'(doe), W'(1));
            check(W'(poe), W'(1));
            check(W'(ecc), W'(0));
        end
        want_v = (kind == 1);
        if (kind == 1) want = mem[ad];
    endtask : op
    task automatic burst(input int kind, input logic [ADDR_W-1:0] b, input logic [3:0] m0, input logic [W-1:0] v);
        logic [ADDR_W-1:0] ad;
        for (int i = 0; i < 4; i++) begin
            ad = b;
            ad[1:0] = (order == ORDER_LINEAR) ? b[1:0] + 2'(i) : b[1:0] ^ 2'(i);
            op(kind, i > 0, ad, m0 & 4'(i), v + W'(i));
        end
    endtask : burst
    task automatic s_single;
        op(2, 0, 20'h00100, 4'h0, 36'h9abcdef01);
        op(1, 0, 20'h00100, 4'h0, '0);
        op(2, 0, 20'h00100, 4'ha, 36'h123456789);
        op(1, 0, 20'h00100, 4'h0, '0);
        op(2, 0, 20'h00100, 4'hf, 36'h0f0f0f0f0);
        op(1, 0, 20'h00100, 4'h0, '0);
        op(0, 0, '0, 4'h0, '0);
    endtask : s_single
    task automatic s_burst;
        burst(2, 20'h00202, 4'h0, 36'h111111111);
        order = ORDER_INTERLEAVED;
        burst(1, 20'h00201, 4'h0, '0);
        burst(2, 20'h00203, 4'hf, 36'h8a8b8c8d8);
        order = ORDER_LINEAR;
        burst(1, 20'h00200, 4'h0, '0);
        op(0, 0, '0, 4'h0, '0);
    endtask : s_burst
    task automatic s_stall;
        op(1, 0, 20'h00202, 4'h0, '0);
        op(0, 0, '0, 4'h0, '0);
        qn = 1;
        repeat (3) @(negedge clk);
        check({plo, dlo}, mem[20'h00202]);
        check(W'(doe), W'(1));
        qn = 0;
        @(negedge clk);
        check(W'(doe), W'(0));
        op(1, 0, 20'h00100, 4'h0, '0);
        want_v = 0;
        @(negedge clk);
        odn = 1;
        #1 check(W'(doe), W'(0));
        @(negedge clk);
        odn = 0;
        #1 check(W'(doe), W'(1));
    endtask : s_stall
    task automatic s_sleep;
        @(negedge clk);
        // the device must be deselected before sleep is asked for
        {cs1n, cs2, cs3n} = 3'b101;
        @(negedge clk);
        slp = 1;
        repeat (3) @(negedge clk);
        check(W'(pwr), W'(POWER_ASLEEP));
        {cs1n, cs2, cs3n, wn} = 4'b0101;
        repeat (2) @(negedge clk);
        check(W'(doe), W'(0));
        {cs1n, cs2, cs3n} = 3'b101;
        slp = 0;
        repeat (3) @(negedge clk);
        check(W'({pwr, doe}), W'(0));
        op(1, 0, 20'h00203, 4'h0, '0);
        op(0, 0, '0, 4'h0, '0);
    endtask : s_sleep
    task automatic conclude;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge clk);
        check(W'({doe, poe, pwr, ecc}), W'(0));
        rstn = 1;
        s_single();
        s_burst();
        s_stall();
        s_sleep();
        check(W'(clash), W'(0));
        conclude();
    end
endmodule : test_pipelined_burst_sram_port
